// file: pic_consts.svh
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH
// ==========================================================
// register index map (plain port, one 16-bit word each)
`define PIC_ADDR_FLAG     8'h00
`define PIC_ADDR_ENABLE   8'h01
`define PIC_ADDR_PRIO0    8'h02
`define PIC_ADDR_PRIO3    8'h05
`define PIC_ADDR_CTL1     8'h06
`define PIC_ADDR_CTL2     8'h07
`define PIC_ADDR_CTL3     8'h08
`define PIC_ADDR_CTL4     8'h09
`define PIC_ADDR_PEND     8'h0a
`define PIC_ADDR_STATUS   8'h0b
`define PIC_ADDR_CORE     8'h0c
`define PIC_ADDR_IST      8'h0d
`define PIC_ADDR_IMASK    8'h0e
// ==========================================================
// field positions
`define PIC_CTL1_NEST_BIT   15
`define PIC_CTL1_TRAP_LSB   1
`define PIC_CTL1_TRAP_MSB   4
`define PIC_CTL2_GIE_BIT    15
`define PIC_CTL2_ALT_BIT    8
`define PIC_CTL2_POL_MSB    3
`define PIC_CTL3_PLL_BIT    0
`define PIC_CTL3_DO_BIT     4
`define PIC_CTL4_SOFT_HARD_TRAP_STATUS_BIT   0
`define PIC_PEND_LVL_LSB    8
`define PIC_STATUS_LVL_LSB  5
`define PIC_STATUS_LVL_MSB  7
`define PIC_CORE_TOP_BIT    3
`define PIC_PRIO_FIELD_W    4
// ==========================================================
// reset values and constants
`define PIC_GIE_RST         1'b1
`define PIC_VEC_BASE        8'h08
`define PIC_LVL_MAX_LOW     3'h7
`define PIC_WORD_ZERO       16'h0000
`endif

// file: pic_pkg.sv
package pic_pkg;
	typedef logic [15:0] pic_word_t;
	typedef logic [2:0]  pic_prio_t;
	// what the cpu sees of the pending-vector register
	typedef struct packed {
		logic       valid;
		logic [3:0] level;
		logic [7:0] pending_vector_number;
	} pic_pend_s;
	// register port request
	typedef struct packed {
		logic      wr;
		logic      rd;
		logic [7:0] addr;
		pic_word_t data;
	} pic_bus_s;
endpackage : pic_pkg

// file: pic_arbiter.sv
`timescale 1ns/1ps
module pic_arbiter import pic_pkg::*; (
	input  wire logic [15:0]           flag_i,
	input  wire logic [15:0]           enable_i,
	input  wire logic [15:0][2:0]      prio_i,
	input  wire logic                  gie_i,
	input  wire logic [3:0]            cpu_level_i,
	output logic                       win_valid_o,
	output logic [3:0]                 win_idx_o,
	output pic_prio_t                  win_prio_o
);
	// ==========================================================
	// arbitration
	// strict compare keeps the earlier (lower vector) source on a tie
	always_comb begin
		win_valid_o = 1'b0;
		win_idx_o   = 4'h0;
		win_prio_o  = 3'h0;
		for (int i = 0; i < 16; i++) begin
			if (flag_i[i] && enable_i[i] && gie_i
			    && ({1'b0, prio_i[i]} > cpu_level_i)
			    && (!win_valid_o || prio_i[i] > win_prio_o)) begin
				win_valid_o = 1'b1;
				win_idx_o   = 4'(i);
				win_prio_o  = prio_i[i];
			end
		end
	end
endmodule : pic_arbiter

// file: pic_controller.sv
`timescale 1ns/1ps
`include "pic_consts.svh"
// Function
// - every source owns a request flag, set by its event and held until software clears it.
// - every source owns an enable bit that gates whether it may interrupt.
// - every source owns a three-bit priority field holding levels zero to seven; level zero never interrupts.
// - a pending interrupt latches its vector number and its priority into the pending-vector register.
// - bit positions follow vector order, external request zero is bit 0 with vector 8.
// - control one holds nesting disable plus the trap status flags.
// - control two holds external request edge polarity, global enable and alternate table enable.
// - control three holds the auxiliary pll trap and loop stack overflow trap flags.
// - control four holds the software generated hard trap status.
// - the cpu status register holds the low three cpu priority bits, writable by software.
// - the top cpu priority bit sits in the core control register and is read-only.
module pic_controller import pic_pkg::*; (
	input  wire logic        sys_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output pic_word_t        rd_data_o,
	input  wire logic [3:0]  ext_req_i,
	input  wire logic [11:0] periph_evt_i,
	input  wire logic [3:0]  trap_evt_i,
	input  wire logic        aux_pll_trap_i,
	input  wire logic        do_ovf_trap_i,
	input  wire logic        soft_hard_trap_i,
	input  wire logic        cpu_ack_i,
	output pic_pend_s        cpu_req_o,
	output logic             alt_vec_o,
	output logic             irq_o
);
	// ==========================================================
	// helpers
	function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] idx);
		wr_hit = w && (a == idx);
	endfunction : wr_hit

	// ==========================================================
	// external request synchroniser
	logic [3:0] ext_s1;
	logic [3:0] ext_s2;
	logic [3:0] ext_s3;
	logic [3:0] ext_pol;
	logic [3:0] ext_evt;

	// pins are asynchronous, two flops before anything looks at them
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext_s1 <= 4'h0;
			ext_s2 <= 4'h0;
			ext_s3 <= 4'h0;
		end else if (ce_i) begin
			ext_s1 <= ext_req_i;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	// polarity 0 rising edge, 1 falling edge
	always_comb begin
		ext_evt = (~ext_pol & ext_s2 & ~ext_s3) | (ext_pol & ~ext_s2 & ext_s3);
	end

	// ==========================================================
	// register state
	logic [15:0]      flag_bank;
	logic [15:0]      enable_bank;
	logic [15:0][2:0] prio_bank;
	logic             nest_dis;
	logic [3:0]       trap_flags;
	logic             global_irq_enable;
	logic             alt_en;
	logic             aux_pll_flag;
	logic             do_ovf_flag;
	logic             soft_hard_trap_status_flag;
	logic [2:0]       cpu_lvl_low;
	logic             cpu_top;
	logic [1:0]       ist;
	logic [1:0]       imask;
	pic_pend_s        pend;

	logic [15:0]      next_flag_bank;
	logic [15:0]      next_enable_bank;
	logic [15:0][2:0] next_prio_bank;
	logic             next_nest_dis;
	logic [3:0]       next_trap_flags;
	logic             next_gie;
	logic [3:0]       next_ext_pol;
	logic             next_alt_en;
	logic             next_aux_pll_flag;
	logic             next_do_ovf_flag;
	logic             next_soft_hard_trap_status_flag;
	logic [2:0]       next_cpu_lvl_low;
	logic             next_cpu_top;
	logic [1:0]       next_ist;
	logic [1:0]       next_imask;
	pic_pend_s        next_pend;

	logic [15:0]      src_evt;
	logic             win_valid;
	logic [3:0]       win_idx;
	pic_prio_t        win_prio;
	logic             any_trap_evt;

	// ext requests take the lowest positions, peripherals follow
	assign src_evt      = {periph_evt_i, ext_evt};
	assign any_trap_evt = |trap_evt_i | aux_pll_trap_i | do_ovf_trap_i | soft_hard_trap_i;

	pic_arbiter u_arbiter (
		.flag_i      (flag_bank),
		.enable_i    (enable_bank),
		.prio_i      (prio_bank),
		.gie_i       (global_irq_enable),
		.cpu_level_i ({cpu_top, cpu_lvl_low}),
		.win_valid_o (win_valid),
		.win_idx_o   (win_idx),
		.win_prio_o  (win_prio)
	);

	// next values; hardware sets always win over a software clear
	always_comb begin
		next_flag_bank = flag_bank;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_FLAG))
			next_flag_bank = wr_data_i;
		next_flag_bank = next_flag_bank | src_evt;

		next_enable_bank = enable_bank;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_ENABLE))
			next_enable_bank = wr_data_i;

		next_prio_bank = prio_bank;
		for (int r = 0; r < 4; r++) begin
			if (wr_hit(wr_i, addr_i, 8'(`PIC_ADDR_PRIO0 + r))) begin
				for (int n = 0; n < 4; n++)
					next_prio_bank[4*r+n] = wr_data_i[`PIC_PRIO_FIELD_W*n +: 3];
			end
		end

		next_nest_dis   = nest_dis;
		next_trap_flags = trap_flags;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_CTL1)) begin
			next_nest_dis   = wr_data_i[`PIC_CTL1_NEST_BIT];
			next_trap_flags = wr_data_i[`PIC_CTL1_TRAP_MSB:`PIC_CTL1_TRAP_LSB];
		end
		next_trap_flags = next_trap_flags | trap_evt_i;

		next_gie     = global_irq_enable;
		next_alt_en  = alt_en;
		next_ext_pol = ext_pol;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_CTL2)) begin
			next_gie     = wr_data_i[`PIC_CTL2_GIE_BIT];
			next_alt_en  = wr_data_i[`PIC_CTL2_ALT_BIT];
			next_ext_pol = wr_data_i[`PIC_CTL2_POL_MSB:0];
		end

		next_aux_pll_flag = aux_pll_flag;
		next_do_ovf_flag  = do_ovf_flag;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_CTL3)) begin
			next_aux_pll_flag = wr_data_i[`PIC_CTL3_PLL_BIT];
			next_do_ovf_flag  = wr_data_i[`PIC_CTL3_DO_BIT];
		end
		next_aux_pll_flag = next_aux_pll_flag | aux_pll_trap_i;
		next_do_ovf_flag  = next_do_ovf_flag | do_ovf_trap_i;

		next_soft_hard_trap_status_flag = soft_hard_trap_status_flag;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_CTL4))
			next_soft_hard_trap_status_flag = wr_data_i[`PIC_CTL4_SOFT_HARD_TRAP_STATUS_BIT];
		next_soft_hard_trap_status_flag = next_soft_hard_trap_status_flag | soft_hard_trap_i;

		// nesting disable parks the cpu at level seven on every entry
		next_cpu_lvl_low = cpu_lvl_low;
		if (cpu_ack_i && pend.valid)
			next_cpu_lvl_low = nest_dis ? `PIC_LVL_MAX_LOW : pend.level[2:0];
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_STATUS))
			next_cpu_lvl_low = wr_data_i[`PIC_STATUS_LVL_MSB:`PIC_STATUS_LVL_LSB];

		// top bit follows trap state only, writes to the core register cannot touch it
		next_cpu_top = |next_trap_flags | next_aux_pll_flag | next_do_ovf_flag | next_soft_hard_trap_status_flag;

		next_pend = pend;
		next_pend.valid = win_valid;
		if (win_valid) begin
			next_pend.pending_vector_number = `PIC_VEC_BASE + {4'h0, win_idx};
			next_pend.level  = {1'b0, win_prio};
		end

		next_imask = imask;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_IMASK))
			next_imask = wr_data_i[1:0];
		next_ist = ist;
		if (wr_hit(wr_i, addr_i, `PIC_ADDR_IST))
			next_ist = ist & ~wr_data_i[1:0];
		next_ist = next_ist | {any_trap_evt, win_valid & ~pend.valid};
	end

	// register everything; ce low freezes all state
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_bank    <= 16'h0000;
			enable_bank  <= 16'h0000;
			prio_bank    <= '0;
			nest_dis     <= 1'b0;
			trap_flags   <= 4'h0;
			global_irq_enable          <= `PIC_GIE_RST;
			alt_en       <= 1'b0;
			ext_pol      <= 4'h0;
			aux_pll_flag <= 1'b0;
			do_ovf_flag  <= 1'b0;
			soft_hard_trap_status_flag    <= 1'b0;
			cpu_lvl_low  <= 3'h0;
			cpu_top      <= 1'b0;
			ist          <= 2'h0;
			imask        <= 2'h0;
			pend         <= '0;
		end else if (ce_i) begin
			flag_bank    <= next_flag_bank;
			enable_bank  <= next_enable_bank;
			prio_bank    <= next_prio_bank;
			nest_dis     <= next_nest_dis;
			trap_flags   <= next_trap_flags;
			global_irq_enable          <= next_gie;
			alt_en       <= next_alt_en;
			ext_pol      <= next_ext_pol;
			aux_pll_flag <= next_aux_pll_flag;
			do_ovf_flag  <= next_do_ovf_flag;
			soft_hard_trap_status_flag    <= next_soft_hard_trap_status_flag;
			cpu_lvl_low  <= next_cpu_lvl_low;
			cpu_top      <= next_cpu_top;
			ist          <= next_ist;
			imask        <= next_imask;
			pend         <= next_pend;
		end
	end

	// ==========================================================
	// read path and outputs
	pic_word_t next_rd_data;
	logic      next_irq;

	// unmapped addresses read zero
	always_comb begin
		next_rd_data = rd_data_o;
		if (rd_i) begin
			next_rd_data = `PIC_WORD_ZERO;
			unique case (addr_i)
				`PIC_ADDR_FLAG:   next_rd_data = flag_bank;
				`PIC_ADDR_ENABLE: next_rd_data = enable_bank;
				`PIC_ADDR_CTL1: begin
					next_rd_data[`PIC_CTL1_NEST_BIT] = nest_dis;
					next_rd_data[`PIC_CTL1_TRAP_MSB:`PIC_CTL1_TRAP_LSB] = trap_flags;
				end
				`PIC_ADDR_CTL2: begin
					next_rd_data[`PIC_CTL2_GIE_BIT] = global_irq_enable;
					next_rd_data[`PIC_CTL2_ALT_BIT] = alt_en;
					next_rd_data[`PIC_CTL2_POL_MSB:0] = ext_pol;
				end
				`PIC_ADDR_CTL3: begin
					next_rd_data[`PIC_CTL3_PLL_BIT] = aux_pll_flag;
					next_rd_data[`PIC_CTL3_DO_BIT]  = do_ovf_flag;
				end
				`PIC_ADDR_CTL4:   next_rd_data[`PIC_CTL4_SOFT_HARD_TRAP_STATUS_BIT] = soft_hard_trap_status_flag;
				`PIC_ADDR_PEND: begin
					next_rd_data[7:0] = pend.pending_vector_number;
					next_rd_data[`PIC_PEND_LVL_LSB +: 4] = pend.level;
				end
				`PIC_ADDR_STATUS: next_rd_data[`PIC_STATUS_LVL_MSB:`PIC_STATUS_LVL_LSB] = cpu_lvl_low;
				`PIC_ADDR_CORE:   next_rd_data[`PIC_CORE_TOP_BIT] = cpu_top;
				`PIC_ADDR_IST:    next_rd_data[1:0] = ist;
				`PIC_ADDR_IMASK:  next_rd_data[1:0] = imask;
				default: begin
					for (int r = 0; r < 4; r++)
						if (addr_i == 8'(`PIC_ADDR_PRIO0 + r))
							for (int n = 0; n < 4; n++)
								next_rd_data[`PIC_PRIO_FIELD_W*n +: 3] = prio_bank[4*r+n];
				end
			endcase
		end
		next_irq = |(next_ist & next_imask);
	end

	// outputs straight from flops
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o <= `PIC_WORD_ZERO;
			irq_o     <= 1'b0;
			alt_vec_o <= 1'b0;
		end else if (ce_i) begin
			rd_data_o <= next_rd_data;
			irq_o     <= next_irq;
			alt_vec_o <= next_alt_en;
		end
	end

	assign cpu_req_o = pend;

	// ==========================================================
	// assertions
	property p_flag_hold;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(flag_bank[5] && !(ce_i && wr_hit(wr_i, addr_i, `PIC_ADDR_FLAG))) |=> flag_bank[5];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a write");
	property p_enable_gate;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		win_valid |-> (enable_bank[win_idx] && flag_bank[win_idx]);
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("disabled source won");
	property p_prio_write;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && wr_hit(wr_i, addr_i, `PIC_ADDR_PRIO0)) |=> (prio_bank[1] == $past(wr_data_i[6:4]));
	endproperty
	a_prio_write: assert property (p_prio_write) else $error("priority field not stored");
	property p_pend_latch;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && win_valid) |=> (pend.valid && pend.pending_vector_number == 8'($past(win_idx) + 8)
		                         && pend.level == {1'b0, $past(win_prio)});
	endproperty
	a_pend_latch: assert property (p_pend_latch) else $error("pending vector wrong");
	property p_ext_zero;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && ext_evt[0]) |=> flag_bank[0];
	endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("ext zero flag not at bit 0");
	property p_trap_one;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && trap_evt_i[2]) |=> (trap_flags[2] && cpu_top);
	endproperty
	a_trap_one: assert property (p_trap_one) else $error("trap flag not set");
	property p_gie_off;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && !global_irq_enable) |=> !cpu_req_o.valid;
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("request with global enable off");
	property p_trap_three;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && aux_pll_trap_i && do_ovf_trap_i) |=> (aux_pll_flag && do_ovf_flag);
	endproperty
	a_trap_three: assert property (p_trap_three) else $error("control three flag missed");
	property p_soft_hard_trap_status;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && soft_hard_trap_i) |=> soft_hard_trap_status_flag;
	endproperty
	a_soft_hard_trap_status: assert property (p_soft_hard_trap_status) else $error("soft hard trap not recorded");
	property p_status_write;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && wr_hit(wr_i, addr_i, `PIC_ADDR_STATUS)) |=> (cpu_lvl_low == $past(wr_data_i[7:5]));
	endproperty
	a_status_write: assert property (p_status_write) else $error("cpu level write lost");
	property p_top_ro;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(ce_i && wr_hit(wr_i, addr_i, `PIC_ADDR_CORE) && !cpu_top && !any_trap_evt) |=> !cpu_top;
	endproperty
	a_top_ro: assert property (p_top_ro) else $error("top level bit written");
	property p_above_level;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		win_valid |-> (global_irq_enable && {1'b0, win_prio} > {cpu_top, cpu_lvl_low});
	endproperty
	a_above_level: assert property (p_above_level) else $error("winner not above cpu level");
	property p_tie_low;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(win_valid && win_idx != 4'h0 && flag_bank[0] && enable_bank[0]) |-> (prio_bank[0] < win_prio);
	endproperty
	a_tie_low: assert property (p_tie_low) else $error("tie not resolved to lower vector");
endmodule : pic_controller

// file: pic_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// cpu core stand-in: accepts a pending interrupt after dly_i idle cycles
module pic_cpu_model import pic_pkg::*; (
	input  wire logic       sys_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       en_i,
	input  wire logic [3:0] dly_i,
	input  wire pic_pend_s  req_i,
	output logic            ack_o
);
	int cnt;

	// hold-off after each ack, so a request that is about to drop is never acked twice
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt   <= 0;
			ack_o <= 1'b0;
		end else begin
			ack_o <= 1'b0;
			if (cnt < 0) begin
				cnt <= cnt + 1;
			end else if (en_i && req_i.valid === 1'b1) begin
				if (cnt >= int'(dly_i)) begin
					ack_o <= 1'b1; // ack only while valid
					cnt   <= -4;
				end else begin
					cnt <= cnt + 1;
				end
			end else begin
				cnt <= 0;
			end
		end
	end
endmodule : pic_cpu_model

// file: pic_controller_tb_top.sv
`timescale 1ns/1ps
`include "pic_consts.svh"
module pic_controller_tb_top import pic_pkg::*;;
	logic sys_clk, arst_n, ce, wr, rd, pll, dov, sht, ack, alt, irq, en;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic [3:0]  ext, trap, dly;
	logic [11:0] pev;
	pic_word_t   rdata;
	pic_pend_s   req;
	int          fails, n_tests;

	pic_controller i_pic_controller (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .ce_i(ce), .addr_i(addr),
		.wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .ext_req_i(ext), .periph_evt_i(pev),
		.trap_evt_i(trap), .aux_pll_trap_i(pll), .do_ovf_trap_i(dov), .soft_hard_trap_i(sht),
		.cpu_ack_i(ack), .cpu_req_o(req), .alt_vec_o(alt), .irq_o(irq));
	pic_cpu_model i_pic_cpu_model (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .en_i(en), .dly_i(dly),
		.req_i(req), .ack_o(ack));

	// ==========================================================
	// shared tasks
	task automatic results();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// one idle cycle between strobes keeps each strobe a single assignment per step
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		check(nm, rdata, exp);
	endtask : rdchk

	task automatic evt(input logic [11:0] p, input logic [3:0] t, input logic [2:0] m);
		@(posedge sys_clk);
		pev <= p;
		trap <= t;
		{pll, dov, sht} <= m;
		@(posedge sys_clk);
		pev <= '0;
		trap <= '0;
		{pll, dov, sht} <= '0;
	endtask : evt

	task automatic settle();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic wait_req();
		int i;
		// let the edge's register updates land before looking
		#1;
		for (i = 0; i < 20 && req.valid !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		if (i == 20) begin
			fails++;
			$display("mismatch wait_req expected 1 seen 0");
			results();
		end
	endtask : wait_req

	function automatic logic [15:0] pend(input logic [3:0] l, input logic [7:0] v);
		return {3'h0, 1'b1, l, v};
	endfunction : pend

	// ==========================================================
	// scenarios
	task automatic s_reset();
		check("req", {3'h0, req}, 16'h0000);
		check("irq", {15'h0, irq}, 16'h0000);
		rdchk("ctl2", `PIC_ADDR_CTL2, 16'h8000);
		rdchk("flag", `PIC_ADDR_FLAG, 16'h0000);
		rdchk("unmapped", 8'h20, 16'h0000);
	endtask : s_reset

	// source 4 flag, enable and global enable gating
	task automatic s_basic();
		wreg(`PIC_ADDR_ENABLE, 16'h0010);
		wreg(`PIC_ADDR_PRIO0 + 8'h01, 16'h0003);
		evt(12'h001, 4'h0, 3'h0);
		wait_req();
		check("req", {3'h0, req}, pend(4'h3, 8'h0c));
		rdchk("pend", `PIC_ADDR_PEND, 16'h030c);
		settle();
		rdchk("flag", `PIC_ADDR_FLAG, 16'h0010);
		wreg(`PIC_ADDR_FLAG, 16'h0000);
		settle();
		check("req_clr", {15'h0, req.valid}, 16'h0000);
		wreg(`PIC_ADDR_ENABLE, 16'h0000);
		evt(12'h001, 4'h0, 3'h0);
		settle();
		check("req_dis", {15'h0, req.valid}, 16'h0000);
		wreg(`PIC_ADDR_ENABLE, 16'h0010);
		wait_req();
		wreg(`PIC_ADDR_CTL2, 16'h0000);
		settle();
		check("req_gie", {15'h0, req.valid}, 16'h0000);
		wreg(`PIC_ADDR_CTL2, 16'h8100);
		wait_req();
		check("alt", {15'h0, alt}, 16'h0001);
		rdchk("ctl2", `PIC_ADDR_CTL2, 16'h8100);
		wreg(`PIC_ADDR_FLAG, 16'h0000);
	endtask : s_basic

	// ties, cpu level masking and cpu acceptance
	task automatic s_arbit();
		wreg(`PIC_ADDR_PRIO0 + 8'h01, 16'h5523);
		wreg(`PIC_ADDR_ENABLE, 16'h00f0);
		evt(12'h00e, 4'h0, 3'h0);
		wait_req();
		check("req_tie", {3'h0, req}, pend(4'h5, 8'h0e));
		wreg(`PIC_ADDR_STATUS, 16'h00a0);
		settle();
		check("req_lvl", {15'h0, req.valid}, 16'h0000);
		rdchk("status", `PIC_ADDR_STATUS, 16'h00a0);
		wreg(`PIC_ADDR_STATUS, 16'h0080);
		wait_req();
		check("req_lvl4", {3'h0, req}, pend(4'h5, 8'h0e));
		wreg(`PIC_ADDR_STATUS, 16'h0000);
		en <= 1'b1;
		dly <= 4'h4;
		repeat (3) settle();
		rdchk("ack_slow", `PIC_ADDR_STATUS, 16'h00a0);
		check("req_ack", {15'h0, req.valid}, 16'h0000);
		dly <= 4'h0;
		wreg(`PIC_ADDR_CTL1, 16'h8000);
		wreg(`PIC_ADDR_STATUS, 16'h0000);
		repeat (2) settle();
		rdchk("ack_fast", `PIC_ADDR_STATUS, 16'h00e0);
		en <= 1'b0;
		wreg(`PIC_ADDR_FLAG, 16'h0000);
		wreg(`PIC_ADDR_CTL1, 16'h0000);
		wreg(`PIC_ADDR_STATUS, 16'h0000);
	endtask : s_arbit

	// external request zero, both edge polarities
	task automatic s_ext();
		wreg(`PIC_ADDR_PRIO0, 16'h0007);
		wreg(`PIC_ADDR_ENABLE, 16'h0001);
		@(posedge sys_clk);
		ext <= 4'h1;
		wait_req();
		check("req_ext", {3'h0, req}, pend(4'h7, 8'h08));
		rdchk("flag_ext", `PIC_ADDR_FLAG, 16'h0001);
		wreg(`PIC_ADDR_CTL2, 16'h8101);
		wreg(`PIC_ADDR_FLAG, 16'h0000);
		@(posedge sys_clk);
		ext <= 4'h0;
		settle();
		wait_req();
		rdchk("flag_fall", `PIC_ADDR_FLAG, 16'h0001);
		wreg(`PIC_ADDR_FLAG, 16'h0000);
		@(posedge sys_clk);
		ext <= 4'h1;
		settle();
		rdchk("flag_rise", `PIC_ADDR_FLAG, 16'h0000);
	endtask : s_ext

	// status, mask and level interrupt output
	task automatic s_irq();
		wreg(`PIC_ADDR_IST, 16'h0003);
		wreg(`PIC_ADDR_IMASK, 16'h0000);
		wreg(`PIC_ADDR_ENABLE, 16'h0010);
		evt(12'h001, 4'h0, 3'h0);
		wait_req();
		settle();
		check("irq_mask", {15'h0, irq}, 16'h0000);
		wreg(`PIC_ADDR_IMASK, 16'h0001);
		settle();
		check("irq_on", {15'h0, irq}, 16'h0001);
		wreg(`PIC_ADDR_FLAG, 16'h0000);
		wreg(`PIC_ADDR_IST, 16'h0001);
		settle();
		check("irq_clr", {15'h0, irq}, 16'h0000);
	endtask : s_irq

	// trap flags and the read-only top priority bit
	task automatic s_trap();
		wreg(`PIC_ADDR_CTL1, 16'h8000);
		rdchk("ctl1_nest", `PIC_ADDR_CTL1, 16'h8000);
		evt(12'h000, 4'h5, 3'h0);
		rdchk("ctl1_trap", `PIC_ADDR_CTL1, 16'h800a);
		rdchk("core", `PIC_ADDR_CORE, 16'h0008);
		wreg(`PIC_ADDR_CORE, 16'h0000);
		rdchk("core_ro", `PIC_ADDR_CORE, 16'h0008);
		wreg(`PIC_ADDR_CTL1, 16'h0000);
		rdchk("core_clr", `PIC_ADDR_CORE, 16'h0000);
		wreg(`PIC_ADDR_CORE, 16'h0008);
		rdchk("core_ro0", `PIC_ADDR_CORE, 16'h0000);
		evt(12'h000, 4'h0, 3'h6);
		rdchk("ctl3", `PIC_ADDR_CTL3, 16'h0011);
		evt(12'h000, 4'h0, 3'h1);
		rdchk("ctl4", `PIC_ADDR_CTL4, 16'h0001);
	endtask : s_trap

	// clock enable freeze, then a reset in mid-run
	task automatic s_freeze();
		@(posedge sys_clk);
		ce <= 1'b0;
		wreg(`PIC_ADDR_ENABLE, 16'h0020);
		@(posedge sys_clk);
		ce <= 1'b1;
		rdchk("en_frozen", `PIC_ADDR_ENABLE, 16'h0010);
		@(posedge sys_clk);
		arst_n <= 1'b0;
		@(posedge sys_clk);
		arst_n <= 1'b1;
		#1;
		check("req_rst", {3'h0, req}, 16'h0000);
		check("alt_rst", {15'h0, alt}, 16'h0000);
		rdchk("core_rst", `PIC_ADDR_CORE, 16'h0000);
		rdchk("ctl2_rst", `PIC_ADDR_CTL2, 16'h8000);
	endtask : s_freeze

	// ==========================================================
	// clock, reset and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		{arst_n, wr, rd, pll, dov, sht, en} = '0;
		ce = 1'b1;
		addr = '0;
		wdata = '0;
		{ext, trap, dly} = '0;
		pev = '0;
		fails = 0;
		n_tests = 0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		#1;
		s_reset();
		s_basic();
		s_arbit();
		s_ext();
		s_irq();
		s_trap();
		s_freeze();
		results();
	end
endmodule : pic_controller_tb_top
